// *** rtl/lpmc_ctrl.sv ***
/*
 * Low-power mode controller: range and wait-state check, mode sequencer,
 * clock and power gating outputs, wakeup qualification, APB registers, irq.
 * Assumes synchronous wakeup inputs and an APB master on the same clock.
 */
// Local design decisions: register access over APB and the register addresses.
//
// Behaviour
// R1 - range 1 allows a core clock up to 32 MHz
// R2 - range 2 limits the core clock to 16 MHz
// R3 - range 3 limits the core clock to 4.2 MHz, no wait states
// R4 - range 1 uses one wait state above 16 MHz, else none
// R5 - range 2 uses one wait state above 8 MHz, else none
// R6 - sleep halts only the core; any peripheral event wakes it (code: only events enabled in wake_en wake sleep)
// R7 - low-power run uses slow multispeed clock, at most 131 kHz, regulator low
// R8 - low-power sleep wakes into run with the regulator fully on
// R9 - stop with timekeeping gates core clocks and fast oscillators, keeps slow ones
// R10 - in stop a wakeup-capable peripheral may turn on the fast internal osc
// R11 - any event line wakes stop; core resumes within 3.5 us (code: only R12/R13 sources enabled in wake_en wake stop)
// R12 - stop wake sources: pins, detector, comparators, serial and timer events
// R13 - stop with timekeeping also wakes on timekeeping events
// R14 - stop without timekeeping stops every clock, retains state
// R15 - standby powers off core domain, keeps always-on logic and cause
// R16 - standby with timekeeping exits within 60 us on listed sources
// R17 - standby without timekeeping exits on reset pin or wakeup pin only
// R18 - stop and standby leave timekeeping and watchdog running
// R19 - one mode state, changed only by entry request or qualifying wakeup
`timescale 1ns/100ps
module lpmc_ctrl (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // wakeup sources and stop fast-osc requests
   input wire lpmc_pkg::lpmc_wake_t wake_in,
   input wire logic fast_int_req,
   // power and clock controls
   output lpmc_pkg::lpmc_power_t power,
   output logic rtc_clk_en,
   output logic wdg_clk_en,
   output logic [15:0] core_freq_khz,
   output logic flash_wait,
   output logic irq
);

   lpmc_pkg::lpmc_mode_t mode;
   lpmc_pkg::lpmc_mode_t next_mode;
   lpmc_pkg::lpmc_mode_t from_mode;
   logic [1:0] range;
   logic timekeep;
   logic cmp2_ref;
   logic rtc_en;
   logic wdg_en;
   logic [15:0] freq_req;
   logic [31:0] wake_en;
   logic [31:0] irq_stat;
   logic [31:0] irq_en;
   logic [31:0] cause;
   logic [31:0] wake_prev;
   logic [31:0] wake_now;
   logic [31:0] wake_rise;
   logic [31:0] stop_mask;
   logic [31:0] stby_mask;
   logic [15:0] wake_cnt;
   logic [15:0] next_freq;
   logic next_wait;
   logic freq_ok;
   logic stop_hit;
   logic stby_hit;
   logic any_hit;
   logic tk_now;
   logic wr;
   logic rd;
   logic [3:0] req_cmd;
   lpmc_pkg::lpmc_wake_t m;
   lpmc_pkg::lpmc_power_t next_power;

   // frequency limit of a range
   function automatic logic [15:0] range_max(input logic [1:0] r);
      unique case (r)
         2'h1: range_max = lpmc_pkg::FREQ_RANGE1_MAX_KHZ; // R1
         2'h2: range_max = lpmc_pkg::FREQ_RANGE2_MAX_KHZ; // R2
         default: range_max = lpmc_pkg::FREQ_RANGE3_MAX_KHZ; // R3
      endcase
   endfunction : range_max

   // flash wait state for a frequency in a range
   function automatic logic wait_for(input logic [1:0] r, input logic [15:0] f);
      unique case (r)
         2'h1: wait_for = f > lpmc_pkg::FREQ_RANGE1_WS_KHZ; // R4
         2'h2: wait_for = f > lpmc_pkg::FREQ_RANGE2_WS_KHZ; // R5
         default: wait_for = 1'b0; // R3
      endcase
   endfunction : wait_for

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign req_cmd = pwdata[lpmc_pkg::CTRL_REQ_LSB +: 4];
   assign wake_now = wake_in;
   assign wake_rise = wake_now & ~wake_prev;
   assign freq_ok = freq_req <= range_max(range);
   // timekeeping choice as written with the entry request, so slow oscs never blink
   assign tk_now = (wr && paddr == lpmc_pkg::OFS_CTRL) ?
      pwdata[lpmc_pkg::CTRL_TIMEKEEP_BIT] : timekeep;

   // stop sources: pins, detector, comparators, serial and timer events
   always_comb begin
      m = '0;
      m.gpio = '1; // R12
      m.voltage_detector_out = 1'b1;
      m.cmp1 = 1'b1;
      m.cmp2 = cmp2_ref;
      m.serial = 1'b1;
      m.low_power_serial_port = 1'b1;
      m.lptim = 1'b1;
      m.rtc_alarm_a = timekeep; // R13
      m.rtc_alarm_b = timekeep;
      m.rtc_tamper = timekeep;
      m.rtc_stamp = timekeep;
      m.rtc_wakeup = timekeep;
      stop_mask = m & wake_en; // R11
   end

   // standby sources: reset pin, wakeup pin edges, and timekeeping set
   always_comb begin
      stby_mask = '0;
      stby_mask[18] = 1'b1; // R17
      stby_mask[18:16] = '1;
      stby_mask[19] = 1'b1;
      stby_mask[20] = timekeep; // R16
      stby_mask[25:21] = {5{timekeep}};
   end

   assign stop_hit = |(wake_now & stop_mask);
   assign stby_hit = |(wake_rise & stby_mask);
   assign any_hit = |(wake_now & wake_en);

   // mode sequencer
   always_comb begin
      next_mode = mode;
      unique case (mode)
         lpmc_pkg::M_RUN, lpmc_pkg::M_LP_RUN: begin
            if (wr && paddr == lpmc_pkg::OFS_CTRL) begin // R19
               unique case (req_cmd)
                  lpmc_pkg::REQ_SLEEP: next_mode = lpmc_pkg::M_SLEEP;
                  lpmc_pkg::REQ_LP_RUN: next_mode = lpmc_pkg::M_LP_RUN;
                  lpmc_pkg::REQ_LP_SLEEP: next_mode = lpmc_pkg::M_LP_SLEEP;
                  lpmc_pkg::REQ_STOP: next_mode = lpmc_pkg::M_STOP;
                  lpmc_pkg::REQ_STANDBY: next_mode = lpmc_pkg::M_STANDBY;
                  lpmc_pkg::REQ_RUN: next_mode = lpmc_pkg::M_RUN;
                  default: next_mode = mode;
               endcase
            end
         end
         lpmc_pkg::M_SLEEP: if (any_hit) next_mode = lpmc_pkg::M_RUN; // R6
         lpmc_pkg::M_LP_SLEEP: if (any_hit) next_mode = lpmc_pkg::M_RUN; // R8
         lpmc_pkg::M_STOP: if (stop_hit) next_mode = lpmc_pkg::M_WAKE; // R11
         lpmc_pkg::M_STANDBY: if (stby_hit) next_mode = lpmc_pkg::M_WAKE; // R16
         lpmc_pkg::M_WAKE: if (wake_cnt == 16'h0000) next_mode = lpmc_pkg::M_RUN;
         default: next_mode = lpmc_pkg::M_RUN;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mode <= lpmc_pkg::M_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // wakeup latency counter, sized to the mode being left
   always_ff @(posedge clock) begin
      if (rst) begin
         wake_cnt <= 16'h0000;
         from_mode <= lpmc_pkg::M_RUN;
      end else if (next_mode == lpmc_pkg::M_WAKE && mode != lpmc_pkg::M_WAKE) begin
         from_mode <= mode;
         if (mode == lpmc_pkg::M_STOP) begin
            wake_cnt <= 16'(lpmc_pkg::STOP_WAKE_CYC - 2); // R11
         end else begin
            wake_cnt <= 16'(lpmc_pkg::STANDBY_WAKE_CYC - 2); // R16
         end
      end else if (wake_cnt != 16'h0000) begin
         wake_cnt <= wake_cnt - 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wake_prev <= '0;
      end else begin
         wake_prev <= wake_now;
      end
   end

   // clock and power control per mode
   always_comb begin
      next_power = '0;
      next_power.core_power_on = 1'b1;
      next_power.retain = 1'b1;
      next_power.slow_ext_en = 1'b1;
      next_power.slow_int_en = 1'b1;
      next_power.periph_clk_en = 1'b1;
      next_power.msi_en = 1'b1;
      next_power.fast_int_en = 1'b1;
      next_power.fast_ext_en = 1'b1;
      next_power.pll_en = 1'b1;
      next_power.core_clk_en = 1'b1;
      unique case (next_mode)
         lpmc_pkg::M_SLEEP: next_power.core_clk_en = 1'b0; // R6
         lpmc_pkg::M_LP_RUN, lpmc_pkg::M_LP_SLEEP: begin
            next_power.core_clk_en = next_mode == lpmc_pkg::M_LP_RUN;
            next_power.reg_lowpower = 1'b1; // R7
            next_power.msi_low_speed = 1'b1;
            next_power.pll_en = 1'b0;
            next_power.fast_ext_en = 1'b0;
            next_power.fast_int_en = 1'b0;
         end
         lpmc_pkg::M_STOP: begin
            next_power.core_clk_en = 1'b0; // R9
            next_power.periph_clk_en = 1'b0;
            next_power.pll_en = 1'b0;
            next_power.msi_en = 1'b0;
            next_power.fast_ext_en = 1'b0;
            next_power.fast_int_en = fast_int_req; // R10
            next_power.reg_lowpower = 1'b1;
            next_power.slow_ext_en = tk_now; // R14
            next_power.slow_int_en = tk_now;
         end
         lpmc_pkg::M_STANDBY: begin
            next_power = '0; // R15
            next_power.slow_ext_en = tk_now;
            next_power.slow_int_en = tk_now;
         end
         lpmc_pkg::M_WAKE: begin
            next_power.core_clk_en = 1'b0;
            // first waking cycle: from_mode is loaded only at this edge
            next_power.retain = (mode == lpmc_pkg::M_WAKE) ? from_mode != lpmc_pkg::M_STANDBY :
               mode != lpmc_pkg::M_STANDBY;
         end
         default: next_power.reg_lowpower = 1'b0; // R8
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         power <= '0;
         power.core_power_on <= 1'b1;
         power.retain <= 1'b1;
         power.core_clk_en <= 1'b1;
         power.periph_clk_en <= 1'b1;
         power.msi_en <= 1'b1;
      end else begin
         power <= next_power;
      end
   end

   // timekeeping and watchdog clocks follow software only
   always_ff @(posedge clock) begin
      if (rst) begin
         rtc_clk_en <= 1'b0;
         wdg_clk_en <= 1'b0;
      end else begin
         rtc_clk_en <= rtc_en; // R18
         wdg_clk_en <= wdg_en; // R18
      end
   end

   // clamped core frequency and wait state
   always_comb begin
      next_freq = freq_ok ? freq_req : range_max(range);
      if (next_mode == lpmc_pkg::M_LP_RUN || next_mode == lpmc_pkg::M_LP_SLEEP) begin
         next_freq = lpmc_pkg::FREQ_LP_MAX_KHZ; // R7
      end
      next_wait = wait_for(range, next_freq);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         core_freq_khz <= lpmc_pkg::FREQ_RESET_KHZ;
         flash_wait <= 1'b0;
      end else begin
         core_freq_khz <= next_freq;
         flash_wait <= next_wait;
      end
   end

   // software registers
   always_ff @(posedge clock) begin
      if (rst) begin
         range <= lpmc_pkg::RANGE_RESET;
         timekeep <= 1'b0;
         cmp2_ref <= 1'b0;
         rtc_en <= 1'b0;
         wdg_en <= 1'b0;
         freq_req <= lpmc_pkg::FREQ_RESET_KHZ;
         wake_en <= lpmc_pkg::WAKE_EN_RESET;
         irq_en <= '0;
      end else if (wr) begin
         unique case (paddr)
            lpmc_pkg::OFS_CTRL: begin
               if (pwdata[lpmc_pkg::CTRL_RANGE_LSB +: 2] != 2'h0) begin
                  range <= pwdata[lpmc_pkg::CTRL_RANGE_LSB +: 2];
               end
               timekeep <= pwdata[lpmc_pkg::CTRL_TIMEKEEP_BIT];
               cmp2_ref <= pwdata[lpmc_pkg::CTRL_CMP2_REF_BIT];
               rtc_en <= pwdata[lpmc_pkg::CTRL_RTC_EN_BIT];
               wdg_en <= pwdata[lpmc_pkg::CTRL_WDG_EN_BIT];
            end
            lpmc_pkg::OFS_FREQ: freq_req <= pwdata[15:0];
            lpmc_pkg::OFS_WAKE_EN: wake_en <= pwdata;
            lpmc_pkg::OFS_IRQ_EN: irq_en <= pwdata;
            default: ;
         endcase
      end
   end

   // sticky wake events and cause; set wins over clear
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_stat <= '0;
         cause <= '0;
      end else begin
         if (wr && paddr == lpmc_pkg::OFS_IRQ_CLR) begin
            irq_stat <= (irq_stat & ~pwdata) | wake_rise;
         end else begin
            irq_stat <= irq_stat | wake_rise;
         end
         if (mode == lpmc_pkg::M_STANDBY && stby_hit) begin
            cause <= wake_rise & stby_mask; // R15
         end else if (wr && paddr == lpmc_pkg::OFS_CAUSE) begin
            cause <= '0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_en);
      end
   end

   // apb answer: zero wait, data registered in setup
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > lpmc_pkg::OFS_CAUSE || paddr[1:0] != 2'h0);
         if (rd) begin
            unique case (paddr)
               lpmc_pkg::OFS_CTRL: prdata <= {22'h0, wdg_en, rtc_en, cmp2_ref, timekeep,
                                              range, 4'h0};
               lpmc_pkg::OFS_FREQ: prdata <= {16'h0, freq_req};
               lpmc_pkg::OFS_STAT: prdata <= {22'h0, freq_ok, flash_wait, mode};
               lpmc_pkg::OFS_WAKE_EN: prdata <= wake_en;
               lpmc_pkg::OFS_IRQ_STAT: prdata <= irq_stat;
               lpmc_pkg::OFS_IRQ_EN: prdata <= irq_en;
               lpmc_pkg::OFS_CAUSE: prdata <= cause;
               default: prdata <= '0;
            endcase
         end
      end
   end

endmodule : lpmc_ctrl

// *** rtl/lpmc_pkg.sv ***
/*
 * Package of the low-power mode controller: register offsets, field layouts,
 * reset values, mode and request encodings, timing counts and carrier structs.
 * Assumes a 100 MHz clock and an APB slave with 32-bit data.
 */
package lpmc_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FREQ = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_WAKE_EN = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
   localparam logic [7:0] OFS_CAUSE = 8'h1C;

   // control register fields
   localparam int CTRL_REQ_LSB = 0;
   localparam int CTRL_RANGE_LSB = 4;
   localparam int CTRL_TIMEKEEP_BIT = 6;
   localparam int CTRL_CMP2_REF_BIT = 7;
   localparam int CTRL_RTC_EN_BIT = 8;
   localparam int CTRL_WDG_EN_BIT = 9;
   localparam logic [1:0] RANGE_RESET = 2'h1;
   localparam logic [31:0] WAKE_EN_RESET = 32'h0000_0000;

   // status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_WAIT_LSB = 8;
   localparam int STAT_CLKOK_BIT = 9;

   // frequency limits in kHz
   localparam logic [15:0] FREQ_RANGE1_MAX_KHZ = 16'd32000;
   localparam logic [15:0] FREQ_RANGE2_MAX_KHZ = 16'd16000;
   localparam logic [15:0] FREQ_RANGE3_MAX_KHZ = 16'd4200;
   localparam logic [15:0] FREQ_RANGE1_WS_KHZ = 16'd16000;
   localparam logic [15:0] FREQ_RANGE2_WS_KHZ = 16'd8000;
   localparam logic [15:0] FREQ_LP_MAX_KHZ = 16'd131;
   localparam logic [15:0] FREQ_RESET_KHZ = 16'd2000;

   // wakeup latencies
   localparam int CLK_MHZ = 100;
   localparam int STOP_WAKE_NS = 3500;
   localparam int STANDBY_WAKE_NS = 60000;
   localparam int STOP_WAKE_CYC = STOP_WAKE_NS * CLK_MHZ / 1000;
   localparam int STANDBY_WAKE_CYC = STANDBY_WAKE_NS * CLK_MHZ / 1000;

   // software entry requests
   typedef enum logic [3:0] {
      REQ_NONE = 4'h0,
      REQ_SLEEP = 4'h1,
      REQ_LP_RUN = 4'h2,
      REQ_LP_SLEEP = 4'h3,
      REQ_STOP = 4'h4,
      REQ_STANDBY = 4'h5,
      REQ_RUN = 4'h6
   } lpmc_req_t;

   // one-hot modes
   typedef enum logic [7:0] {
      M_RUN = 8'h01,
      M_SLEEP = 8'h02,
      M_LP_RUN = 8'h04,
      M_LP_SLEEP = 8'h08,
      M_STOP = 8'h10,
      M_STANDBY = 8'h20,
      M_WAKE = 8'h40
   } lpmc_mode_t;

   // wakeup sources, bit positions in wake bus and enable/status registers
   typedef struct packed {
      logic lptim;
      logic low_power_serial_port;
      logic serial; // usart or i2c wakeup, shared so the bus stays 32 bits
      logic cmp2;
      logic cmp1;
      logic voltage_detector_out;
      logic rtc_wakeup;
      logic rtc_stamp;
      logic rtc_tamper;
      logic rtc_alarm_b;
      logic rtc_alarm_a;
      logic wdg_reset;
      logic ext_reset;
      logic [2:0] wakeup_pin;
      logic [15:0] gpio;
   } lpmc_wake_t;

   // clock and power controls
   typedef struct packed {
      logic core_clk_en;
      logic periph_clk_en;
      logic pll_en;
      logic msi_en;
      logic fast_ext_en;
      logic fast_int_en;
      logic slow_ext_en;
      logic slow_int_en;
      logic reg_lowpower;
      logic core_power_on;
      logic retain;
      logic msi_low_speed;
   } lpmc_power_t;

   localparam int WAKE_W = $bits(lpmc_wake_t);

endpackage : lpmc_pkg

// *** tb/lpmc_asserts.sv ***
/*
 * Port assertions for the low-power mode controller.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module lpmc_asserts (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // controls
   input wire lpmc_pkg::lpmc_power_t power,
   input wire logic rtc_clk_en,
   input wire logic wdg_clk_en,
   input wire logic [15:0] core_freq_khz,
   input wire logic flash_wait
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence bad_addr_s;
      setup_s ##0 (paddr > 8'h1C || paddr[1:0] != 2'h0);
   endsequence
   sequence lp_clock_s;
      (power.msi_en && power.msi_low_speed && power.reg_lowpower)[*3];
   endsequence

   apb_zero_wait_a: assert property (setup_s |=> pready)
      else $error("pready missing after setup");
   pready_single_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   bad_addr_a: assert property (bad_addr_s |=> pready && pslverr)
      else $error("no slave error on bad address");
   freq_cap_a: assert property (core_freq_khz <= lpmc_pkg::FREQ_RANGE1_MAX_KHZ)
      else $error("core clock above top limit");
   low_freq_ws_a: assert property (
      (core_freq_khz <= lpmc_pkg::FREQ_RANGE2_WS_KHZ)[*3] |-> !flash_wait)
      else $error("wait state at low clock");
   lp_clock_a: assert property (lp_clock_s |-> core_freq_khz <= lpmc_pkg::FREQ_LP_MAX_KHZ)
      else $error("low-power clock too fast");
   stop_gating_a: assert property (
      !power.periph_clk_en |-> !power.pll_en && !power.msi_en && !power.fast_ext_en)
      else $error("fast clock running while stopped");
   standby_off_a: assert property (
      !power.core_power_on |-> !power.retain && !power.core_clk_en)
      else $error("core domain state kept while off");
   keep_timekeep_a: assert property (
      $fell(power.periph_clk_en) |-> $stable(rtc_clk_en) && $stable(wdg_clk_en))
      else $error("timekeeping clock changed on entry");
endmodule : lpmc_asserts

bind lpmc_ctrl lpmc_asserts i_asserts (.clock, .rst, .psel, .penable, .paddr, .pready,
   .pslverr, .power, .rtc_clk_en, .wdg_clk_en, .core_freq_khz, .flash_wait);

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the low-power mode controller.
 * Assumes the design package, the design and the checker are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fast_int_req = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, rtc_clk_en, wdg_clk_en, flash_wait, irq;
   logic [15:0] core_freq_khz;
   lpmc_pkg::lpmc_wake_t wake_in = '0;
   lpmc_pkg::lpmc_power_t power;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int mx[3], th[3], f, e;
   logic [32:0] exp_q[$];

   always #5 clock = ~clock;

   lpmc_ctrl i_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .wake_in, .fast_int_req, .power, .rtc_clk_en, .wdg_clk_en,
      .core_freq_khz, .flash_wait, .irq);

   task automatic check_port(string n, logic [31:0] ex, logic [31:0] s, logic [31:0] m);
      total_checks++;
      if ((s & m) !== ex) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, ex, s & m);
      end
   endtask : check_port

   task automatic check_read(logic [32:0] ex, logic [32:0] s);
      total_checks++;
      if (s !== ex) begin
         err_count++;
         $display("ERROR read %h expected %h seen %h", paddr, ex, s);
      end
   endtask : check_read

   // one apb transfer, idle edge after release
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb

   task automatic rd(logic [7:0] a, logic [32:0] ex);
      exp_q.push_back(ex);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic mode(logic [31:0] c);
      apb(1'b1, 8'h00, c);
      repeat (3) @(posedge clock);
   endtask : mode

   task automatic pulse(logic [31:0] m);
      wake_in <= lpmc_pkg::lpmc_wake_t'(m);
      repeat (2) @(posedge clock);
      wake_in <= '0;
      @(posedge clock);
   endtask : pulse

   task automatic pwr(string n, logic [11:0] m, logic [11:0] ex);
      check_port(n, {20'h0, ex}, {20'h0, power}, {20'h0, m});
   endtask : pwr

   // cycles counted from the rising wake edge
   task automatic wait_run(string n, int lim);
      int k;
      k = 3;
      while (power.core_clk_en !== 1'b1 && k <= lim) begin
         @(posedge clock);
         k++;
      end
      check_port(n, 32'h1, 32'(k <= lim), 32'h1);
   endtask : wait_run

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         check_read(exp_q.pop_front(), {pslverr, prdata});
      if (cycles == 40000) begin
         err_count++;
         tally_and_finish();
      end
   end

   initial begin
      void'($urandom(12686));
      mx = '{lpmc_pkg::FREQ_RANGE1_MAX_KHZ, lpmc_pkg::FREQ_RANGE2_MAX_KHZ,
         lpmc_pkg::FREQ_RANGE3_MAX_KHZ};
      th = '{lpmc_pkg::FREQ_RANGE1_WS_KHZ, lpmc_pkg::FREQ_RANGE2_WS_KHZ,
         lpmc_pkg::FREQ_RANGE3_MAX_KHZ};
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      pwr("reset_pwr", 12'hFFF, 12'hD06);
      rd(8'h08, 33'h0_0000_0201);
      rd(8'h0C, 33'h0_0000_0000);
      rd(8'h18, 33'h0_0000_0000);
      rd(8'h20, 33'h1_0000_0000);
      rd(8'h06, 33'h1_0000_0000);
      apb(1'b1, 8'h24, 32'hFFFF_FFFF);
      $display("test reset done");
      apb(1'b1, 8'h14, 32'h0000_0001);
      pulse(32'h0000_0001);
      check_port("irq_set", 32'h1, {31'h0, irq}, 32'h1);
      rd(8'h10, 33'h0_0000_0001);
      apb(1'b1, 8'h18, 32'h0000_0001);
      @(posedge clock);
      check_port("irq_clear", 32'h0, {31'h0, irq}, 32'h1);
      apb(1'b1, 8'h14, 32'h0000_0000);
      pulse(32'h0000_0001);
      check_port("irq_masked", 32'h0, {31'h0, irq}, 32'h1);
      rd(8'h10, 33'h0_0000_0001);
      $display("test irq done");
      apb(1'b1, 8'h0C, 32'h0020_0001);
      mode(32'h0000_0011);
      pwr("sleep_pwr", 12'hC0E, 12'h406);
      pulse(32'h0000_0002);
      pwr("sleep_hold", 12'h800, 12'h000);
      pulse(32'h0000_0001);
      pwr("sleep_wake", 12'h800, 12'h800);
      mode(32'h0000_0013);
      pwr("lpsleep_pwr", 12'hC0E, 12'h40E);
      pulse(32'h0000_0001);
      pwr("lpsleep_wake", 12'h808, 12'h800);
      mode(32'h0000_0012);
      pwr("lprun_pwr", 12'h909, 12'h909);
      check_port("lprun_freq", 32'h83, {16'h0, core_freq_khz}, 32'hFFFF);
      mode(32'h0000_0016);
      pwr("run_back", 12'h808, 12'h800);
      $display("test sleep done");
      mode(32'h0000_0354);
      pwr("stop_pwr", 12'hFCE, 12'h00E);
      check_port("stop_slow", 32'h1, {31'h0, power.slow_ext_en | power.slow_int_en}, 32'h1);
      check_port("stop_keep", 32'h3, {30'h0, rtc_clk_en, wdg_clk_en}, 32'h3);
      fast_int_req <= 1'b1;
      repeat (3) @(posedge clock);
      pwr("stop_fast_int", 12'h840, 12'h040);
      fast_int_req <= 1'b0;
      pulse(32'h0020_0000);
      wait_run("stop_tk_wake", lpmc_pkg::STOP_WAKE_CYC + 4);
      mode(32'h0000_0014);
      pwr("stop_bare_pwr", 12'hFFE, 12'h00E);
      pulse(32'h0020_0000);
      pwr("stop_bare_hold", 12'h800, 12'h000);
      pulse(32'h0000_0001);
      wait_run("stop_bare_wake", lpmc_pkg::STOP_WAKE_CYC + 4);
      $display("test stop done");
      mode(32'h0000_0015);
      pwr("standby_pwr", 12'h806, 12'h000);
      pulse(32'h0020_0001);
      pwr("standby_hold", 12'h004, 12'h000);
      pulse(32'h0002_0000);
      wait_run("standby_wake", lpmc_pkg::STANDBY_WAKE_CYC + 4);
      rd(8'h1C, 33'h0_0002_0000);
      mode(32'h0000_0355);
      check_port("standby_keep", 32'h3, {30'h0, rtc_clk_en, wdg_clk_en}, 32'h3);
      pulse(32'h0200_0000);
      wait_run("standby_tk_wake", lpmc_pkg::STANDBY_WAKE_CYC + 4);
      rd(8'h1C, 33'h0_0200_0000);
      rd(8'h08, 33'h0_0000_0201);
      $display("test standby done");
      for (int r = 0; r < 3; r++) begin
         mode(32'(r + 1) << 4);
         for (int k = 0; k < 5; k++) begin
            f = (k == 0) ? mx[r] : (k == 1) ? th[r] : (k == 2) ? th[r] + 1 :
               (k == 3) ? mx[r] + 32'h1388 : $urandom_range(mx[r] + 32'h07D0, 1);
            e = (f > mx[r]) ? mx[r] : f;
            apb(1'b1, 8'h04, 32'(f));
            repeat (2) @(posedge clock);
            check_port("freq_ws", {15'h0, e > th[r], e[15:0]},
               {15'h0, flash_wait, core_freq_khz}, 32'h1FFFF);
         end
      end
      $display("test freq done");
      tally_and_finish();
   end
endmodule : tb_top
